// ### hdl/dma_irq_enable_mask_pkg.sv
// package: register map, field positions and reset values of the dma interrupt enable mask
package dma_irq_enable_mask_pkg;
    localparam int          NUM_CHAN          = 4;
    localparam int          REG_ADDR_W        = 4;
    localparam int          DATA_W            = 32;
    // byte addresses of the word registers
    localparam logic [3:0]  OFFS_IRQ_ENABLE   = 4'h0;
    localparam logic [3:0]  OFFS_IRQ_STATUS   = 4'h4;
    localparam logic [3:0]  OFFS_IRQ_MASK     = 4'h8;
    localparam logic [3:0]  OFFS_EVENT_RAW    = 4'hC;
    // field positions: finish enable at 2*ch, fault enable at 2*ch+1
    localparam int          POS_CHAN0_FINISH  = 0;
    localparam int          POS_CHAN0_FAULT   = 1;
    localparam int          POS_CHAN1_FINISH  = 2;
    localparam int          POS_CHAN1_FAULT   = 3;
    localparam int          POS_CHAN2_FINISH  = 4;
    localparam int          POS_CHAN2_FAULT   = 5;
    localparam int          POS_CHAN3_FINISH  = 6;
    localparam int          POS_CHAN3_FAULT   = 7;
    localparam int          FIELD_W           = 8;
    localparam logic [7:0]  RST_IRQ_ENABLE    = 8'h00;
    localparam logic [7:0]  RST_IRQ_STATUS    = 8'h00;
    localparam logic [7:0]  RST_IRQ_MASK      = 8'h00;
    localparam logic [31:0] READ_UNMAPPED     = 32'h0000_0000;
endpackage : dma_irq_enable_mask_pkg

// ### hdl/dma_irq_enable_mask.sv
// dma channel interrupt enable mask with sticky status and a level interrupt output
// Contract
// - the channel 3 fault interrupt enable is read-write at bit 7, one enables, reset zero.
// - the channel 3 finish interrupt enable is read-write at bit 6, one enables, reset zero.
// - the channel 2 fault interrupt enable is read-write at bit 5, one enables, reset zero.
// - the channel 2 finish interrupt enable is read-write at bit 4, one enables, reset zero.
// - the channel 1 fault interrupt enable is read-write at bit 3, one enables, reset zero.
// - the channel 1 finish interrupt enable is read-write at bit 2, one enables, reset zero.
// - the channel 0 fault interrupt enable is read-write at bit 1, one enables, reset zero.
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module dma_irq_enable_mask
    import dma_irq_enable_mask_pkg::*;
#(
    parameter int N_CHAN = dma_irq_enable_mask_pkg::NUM_CHAN
) (
    // clock and reset
    input  wire logic                                        clk_sys_i,
    input  wire logic                                        rstn_i,
    // register port
    input  wire logic [dma_irq_enable_mask_pkg::REG_ADDR_W-1:0] reg_addr_i,
    input  wire logic [dma_irq_enable_mask_pkg::DATA_W-1:0]  reg_wdata_i,
    input  wire logic                                        reg_wr_i,
    input  wire logic                                        reg_rd_i,
    output logic      [dma_irq_enable_mask_pkg::DATA_W-1:0]  reg_rdata_o,
    // raw channel events from the dma unit, one-cycle pulses
    input  wire logic [N_CHAN-1:0]                           chan_finish_i,
    input  wire logic [N_CHAN-1:0]                           chan_fault_i,
    // gated events and interrupt
    output logic      [2*N_CHAN-1:0]                         chan_irq_req_o,
    output logic                                             irq_o
);
    import dma_irq_enable_mask_pkg::*;

    localparam int W = 2 * N_CHAN;

    logic [W-1:0]      enable_q;
    logic [W-1:0]      enable_d;
    logic [W-1:0]      status_q;
    logic [W-1:0]      status_d;
    logic [W-1:0]      mask_q;
    logic [W-1:0]      mask_d;
    logic [W-1:0]      raw_evt;
    logic [W-1:0]      gated_evt;
    logic [W-1:0]      req_q;
    logic [W-1:0]      req_d;
    logic              irq_q;
    logic              irq_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;

    // interleave events so each lands on the same bit as its enable
    genvar g;
    generate
        for (g = 0; g < N_CHAN; g++) begin : g_chan
            assign raw_evt[2*g]   = chan_finish_i[g];
            assign raw_evt[2*g+1] = chan_fault_i[g];
        end
    endgenerate

    // disabled events are dropped here, never latched for later
    assign gated_evt = raw_evt & enable_q;

    always_comb begin
        enable_d = enable_q;
        mask_d   = mask_q;
        status_d = status_q;
        if (reg_wr_i && reg_addr_i == OFFS_IRQ_ENABLE) begin
            enable_d = reg_wdata_i[W-1:0];
        end
        if (reg_wr_i && reg_addr_i == OFFS_IRQ_MASK) begin
            mask_d = reg_wdata_i[W-1:0];
        end
        // read clears, but an event in the same cycle still sets
        if (reg_rd_i && reg_addr_i == OFFS_IRQ_STATUS) begin
            status_d = '0;
        end
        status_d = status_d | gated_evt;
    end

    always_comb begin
        req_d   = gated_evt;
        irq_d   = |(status_d & mask_d);
        rdata_d = READ_UNMAPPED;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                OFFS_IRQ_ENABLE: rdata_d[W-1:0] = enable_q;
                OFFS_IRQ_STATUS: rdata_d[W-1:0] = status_q;
                OFFS_IRQ_MASK:   rdata_d[W-1:0] = mask_q;
                OFFS_EVENT_RAW:  rdata_d[W-1:0] = raw_evt;
                default:         rdata_d        = READ_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            enable_q <= '0;
            status_q <= '0;
            mask_q   <= '0;
            req_q    <= '0;
            irq_q    <= 1'b0;
            rdata_q  <= '0;
        end else begin
            enable_q <= enable_d;
            status_q <= status_d;
            mask_q   <= mask_d;
            req_q    <= req_d;
            irq_q    <= irq_d;
            rdata_q  <= rdata_d;
        end
    end

    assign reg_rdata_o    = rdata_q;
    assign chan_irq_req_o = req_q;
    assign irq_o          = irq_q;

endmodule : dma_irq_enable_mask

// ### bench/irq_mask_properties.sv
// gating checks on the channel event outputs of the interrupt enable mask
`timescale 1ns/1ps
module irq_mask_checker
    import dma_irq_enable_mask_pkg::*;
#(parameter int N_CHAN = 4) (
    input wire logic                                     clk_sys_i, rstn_i, reg_wr_i,
    input wire logic [dma_irq_enable_mask_pkg::REG_ADDR_W-1:0] reg_addr_i,
    input wire logic [dma_irq_enable_mask_pkg::DATA_W-1:0]     reg_wdata_i,
    input wire logic [N_CHAN-1:0]                        chan_finish_i, chan_fault_i,
    input wire logic [2*N_CHAN-1:0]                      chan_irq_req_o
);
    logic [2*N_CHAN-1:0] en_q, x_q, g;
    assign g = chan_irq_req_o;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    // shadow of the enable word, so each output bit is tied to its own event and enable
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            en_q <= '0;
            x_q <= '0;
        end else begin
            if (reg_wr_i && reg_addr_i == OFFS_IRQ_ENABLE) en_q <= reg_wdata_i[2*N_CHAN-1:0];
            for (int c = 0; c < N_CHAN; c++)
                x_q[2*c +: 2] <= {chan_fault_i[c], chan_finish_i[c]} & en_q[2*c +: 2];
        end
    end
    a_fault3_gate: assert property (g[7] == x_q[7]) else $error("fault3 gate");
    a_finish3_gate: assert property (g[6] == x_q[6]) else $error("finish3 gate");
    a_fault2_gate: assert property (g[5] == x_q[5]) else $error("fault2 gate");
    a_finish2_gate: assert property (g[4] == x_q[4]) else $error("finish2 gate");
    a_fault1_gate: assert property (g[3] == x_q[3]) else $error("fault1 gate");
    a_finish1_gate: assert property (g[2] == x_q[2]) else $error("finish1 gate");
    a_fault0_gate: assert property (g[1] == x_q[1]) else $error("fault0 gate");
    a_finish0_gate: assert property (g[0] == x_q[0]) else $error("finish0 gate");
endmodule : irq_mask_checker
bind dma_irq_enable_mask irq_mask_checker #(.N_CHAN(N_CHAN)) chk_inst (.*);

// ### bench/tb_top.sv
// self-checking bench for the dma interrupt enable mask
`timescale 1ns/1ps
module tb_top;
    import dma_irq_enable_mask_pkg::*;
    logic        clk_sys_i = 0, rstn_i = 0, wr = 0, rd = 0, irq;
    logic [3:0]  ad = 4'h0, fin = 4'h0, flt = 4'h0;
    logic [31:0] wd = 32'h0000_0000, rdat;
    logic [7:0]  req;
    int          errors = 0, checks = 0, cyc = 0;
    dma_irq_enable_mask dma_irq_enable_mask_inst (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
        .reg_addr_i(ad), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
        .chan_finish_i(fin), .chan_fault_i(flt), .chan_irq_req_o(req), .irq_o(irq));
    initial forever #2.5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        if (++cyc == 3000) begin
            errors++;
            tally_and_finish();
        end
    end
    task automatic cmp(input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    // one register access; for a read, d is the value expected back
    task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        {wr, rd, ad, wd} <= {w, !w, a, d};
        @(posedge clk_sys_i);
        {wr, rd} <= 2'b00;
        #1 if (!w) cmp(rdat, d);
    endtask : acc
    task automatic pulse(input logic [3:0] f, e);
        @(posedge clk_sys_i);
        {fin, flt} <= {f, e};
        @(posedge clk_sys_i);
        {fin, flt} <= 8'h00;
        #1;
    endtask : pulse
    task automatic t_reset;
        acc(0, OFFS_IRQ_ENABLE, 32'h0000_0000);
        acc(0, 4'h1, 32'h0000_0000);
        $display("reset test done");
    endtask : t_reset
    // upper write bits are junk on purpose: they must read back as zero
    task automatic t_gate;
        for (int b = 0; b < 8; b++) begin
            acc(1, OFFS_IRQ_ENABLE, 32'hFFFF_FF00 | (32'h0000_0001 << b));
            acc(0, OFFS_IRQ_ENABLE, 32'h0000_0001 << b);
            pulse(4'hF, 4'hF);
            cmp(req, 32'h0000_0001 << b);
        end
        $display("gate test done");
    endtask : t_gate
    task automatic t_irq;
        acc(0, OFFS_IRQ_STATUS, 32'h0000_00FF);
        acc(1, OFFS_IRQ_MASK, 32'h0000_0080);
        pulse(4'h8, 4'h8);
        cmp(irq, 1);
        acc(0, OFFS_IRQ_STATUS, 32'h0000_0080);
        cmp(irq, 0);
        $display("irq test done");
    endtask : t_irq
    // mask read-back, live raw event word, and an event that lands on a status read
    task automatic t_regs;
        acc(1, OFFS_IRQ_MASK, 32'h0000_005A);
        acc(0, OFFS_IRQ_MASK, 32'h0000_005A);
        @(posedge clk_sys_i);
        {fin, flt, rd, ad} <= {4'h5, 4'hA, 1'b1, OFFS_EVENT_RAW};
        @(posedge clk_sys_i);
        {fin, flt, rd} <= 9'h000;
        #1 cmp(rdat, 32'h0000_0099);
        cmp(req, 32'h0000_0080);
        @(posedge clk_sys_i);
        {flt, rd, ad} <= {4'h8, 1'b1, OFFS_IRQ_STATUS};
        @(posedge clk_sys_i);
        {flt, rd} <= 5'h00;
        #1 cmp(rdat, 32'h0000_0080);
        cmp(irq, 0);
        acc(0, OFFS_IRQ_STATUS, 32'h0000_0080);
        acc(0, OFFS_IRQ_STATUS, 32'h0000_0000);
        $display("register test done");
    endtask : t_regs
    task automatic tally_and_finish;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (6) @(posedge clk_sys_i);
        rstn_i <= 1;
        t_reset();
        t_gate();
        t_irq();
        t_regs();
        tally_and_finish();
    end
endmodule : tb_top
